/* File: logic/vscof_defs.svh */
`ifndef VSCOF_DEFS_SVH
`define VSCOF_DEFS_SVH
`define VSCOF_IDX_SYNC_CTRL 6'h12
`define VSCOF_IDX_PULSE_WIDTH 6'h13
`define VSCOF_IDX_SYNC_PROC 6'h14
`define VSCOF_IDX_COAST_LEAD 6'h16
`define VSCOF_IDX_COAST_TRAIL 6'h17
`define VSCOF_IDX_COAST_CTRL 6'h18
`define VSCOF_IDX_OUT_FORMAT 6'h30
`define VSCOF_IDX_PHASE 6'h31
`define VSCOF_IDX_STATUS 6'h32
`define VSCOF_BIT_SYNC_POL 3
`define VSCOF_BIT_VFILT_EN 2
`define VSCOF_MSB_COAST_SRC 7
`define VSCOF_LSB_COAST_SRC 6
`define VSCOF_BIT_COAST_EXT 7
`define VSCOF_MSB_FMT 1
`define VSCOF_LSB_FMT 0
`define VSCOF_MSB_CLK_SEL 3
`define VSCOF_LSB_CLK_SEL 2
`define VSCOF_BIT_CLK_INV 4
`define VSCOF_MSB_PHASE 4
`define VSCOF_RST_SYNC_CTRL 8'h08
`define VSCOF_RST_PULSE_WIDTH 8'h20
`define VSCOF_RST_SYNC_PROC 8'h04
`define VSCOF_RST_COAST_LEAD 8'h02
`define VSCOF_RST_COAST_TRAIL 8'h0a
`define VSCOF_RST_COAST_CTRL 8'h80
`define VSCOF_RST_OUT_FORMAT 8'h00
`define VSCOF_RST_PHASE 8'h00
`define VSCOF_PIPE_DEPTH 6
`define VSCOF_CLK_TAPS 16
`define VSCOF_RESP_OKAY 2'h0
`define VSCOF_RESP_SLVERR 2'h2
`endif

/* File: logic/vscof_pkg.sv */
package vscof_pkg;
  typedef enum logic [1:0] {
    fmt_444,
    fmt_422,
    fmt_444ddr,
    fmt_spare
  } vscof_fmt_e;
  typedef enum logic [1:0] {
    clk_pixel,
    clk_quad,
    clk_double,
    clk_test
  } vscof_clk_e;
endpackage

/* File: logic/vscof_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module vscof_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: logic/vscof_coast_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module vscof_coast_gen (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // Line and frame events, one-cycle pulses.
  input wire logic i_line_tick,
  input wire logic i_frame_tick,
  // Coast window in lines.
  input wire logic [7:0] i_lead,
  input wire logic [7:0] i_trail,
  // Internal coast level.
  output logic o_coast
);
  logic [11:0] line_cnt;
  logic [11:0] frame_len;
  logic frame_ok;

  // The lead window is predicted from the previous frame's line count.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      line_cnt <= 12'h000;
      frame_len <= 12'h000;
      frame_ok <= 1'b0;
    end else if (i_frame_tick) begin
      line_cnt <= 12'h000;
      frame_len <= line_cnt;
      frame_ok <= 1'b1;
    end else if (i_line_tick && line_cnt != 12'hfff) begin
      line_cnt <= line_cnt + 12'h001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_coast <= 1'b0;
    end else begin
      o_coast <= (line_cnt < {4'h0, i_trail}) ||
                 (frame_ok && (line_cnt + {4'h0, i_lead} >= frame_len));
    end
  end

  sequence s_frame_start;
    i_frame_tick && i_trail != 8'h00 && !i_line_tick;
  endsequence
  sequence s_line_zero;
    line_cnt == 12'h000 ##1 o_coast;
  endsequence
  property p_coast_trail;
    @(posedge i_clock) disable iff (i_srst)
      s_frame_start |=> s_line_zero;
  endproperty
  a_coast_trail: assert property (p_coast_trail) else $error("coast not held after frame start");
endmodule
`default_nettype wire

/* File: logic/vscof_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vscof_defs.svh"
module vscof_formatter (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_srst,
  // AXI4-Lite register slave.
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Video inputs, asynchronous.
  input wire logic i_pixel_clock,
  input wire logic i_hsync,
  input wire logic i_vsync,
  input wire logic i_coast,
  input wire logic [7:0] i_red,
  input wire logic [7:0] i_green,
  input wire logic [7:0] i_blue,
  // Video outputs.
  output logic o_line_sync_output,
  output logic o_output_data_clock,
  output logic [7:0] o_red,
  output logic [7:0] o_green,
  output logic [7:0] o_blue,
  // Clock generator control.
  output logic o_pll_reference,
  output logic o_pll_coast,
  output logic [4:0] o_sample_phase
);
  logic [7:0] sync_ctrl, sync_out_pulse_width, sync_proc;
  logic [7:0] coast_lead_line_count, coast_trail_line_count, coast_ctrl;
  logic [7:0] out_format, phase_reg;
  logic [27:0] sync_bus;
  logic pclk_s, hs_s, vs_s, ext_coast_s;
  logic [23:0] px_in;
  logic pclk_d, pr, pf;
  vscof_pkg::vscof_fmt_e fmt;
  vscof_pkg::vscof_clk_e clk_sel;

  vscof_sync2 #(.W(28)) u_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({i_pixel_clock, i_hsync, i_vsync, i_coast, i_red, i_green, i_blue}),
    .o_sync(sync_bus)
  );
  assign {pclk_s, hs_s, vs_s, ext_coast_s, px_in} = sync_bus;
  assign pr = pclk_s & ~pclk_d;
  assign pf = ~pclk_s & pclk_d;
  assign fmt = vscof_pkg::vscof_fmt_e'(out_format[`VSCOF_MSB_FMT:`VSCOF_LSB_FMT]);
  assign clk_sel = vscof_pkg::vscof_clk_e'(out_format[`VSCOF_MSB_CLK_SEL:`VSCOF_LSB_CLK_SEL]);

  // Register slave; one write and one read in flight at a time.
  logic aw_held, w_held, aw_take, w_take, ar_take, do_write;
  logic next_aw_held, next_w_held, next_bvalid;
  logic [5:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;
  logic pol_high, coast;
  assign aw_take = i_s_axi_awvalid & o_s_axi_awready;
  assign w_take = i_s_axi_wvalid & o_s_axi_wready;
  assign ar_take = i_s_axi_arvalid & o_s_axi_arready;
  assign do_write = aw_held & w_held & ~o_s_axi_bvalid;
  assign next_aw_held = aw_take | (aw_held & ~do_write);
  assign next_w_held = w_take | (w_held & ~do_write);
  assign next_bvalid = do_write | (o_s_axi_bvalid & ~i_s_axi_bready);
  assign wr_ok = (aw_idx == `VSCOF_IDX_SYNC_CTRL) || (aw_idx == `VSCOF_IDX_PULSE_WIDTH) ||
                 (aw_idx == `VSCOF_IDX_SYNC_PROC) || (aw_idx == `VSCOF_IDX_COAST_LEAD) ||
                 (aw_idx == `VSCOF_IDX_COAST_TRAIL) || (aw_idx == `VSCOF_IDX_COAST_CTRL) ||
                 (aw_idx == `VSCOF_IDX_OUT_FORMAT) || (aw_idx == `VSCOF_IDX_PHASE);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `VSCOF_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_take) begin
        aw_idx <= i_s_axi_awaddr[7:2];
      end
      if (w_take) begin
        w_byte <= i_s_axi_wdata[7:0];
        w_lane0 <= i_s_axi_wstrb[0];
      end
      o_s_axi_awready <= ~next_aw_held & ~next_bvalid;
      o_s_axi_wready <= ~next_w_held & ~next_bvalid;
      o_s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        o_s_axi_bresp <= wr_ok ? `VSCOF_RESP_OKAY : `VSCOF_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync_ctrl <= `VSCOF_RST_SYNC_CTRL;
      sync_out_pulse_width <= `VSCOF_RST_PULSE_WIDTH;
      sync_proc <= `VSCOF_RST_SYNC_PROC;
      coast_lead_line_count <= `VSCOF_RST_COAST_LEAD;
      coast_trail_line_count <= `VSCOF_RST_COAST_TRAIL;
      coast_ctrl <= `VSCOF_RST_COAST_CTRL;
      out_format <= `VSCOF_RST_OUT_FORMAT;
      phase_reg <= `VSCOF_RST_PHASE;
    end else if (do_write && w_lane0) begin
      if (aw_idx == `VSCOF_IDX_SYNC_CTRL) begin
        sync_ctrl <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_PULSE_WIDTH) begin
        sync_out_pulse_width <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_SYNC_PROC) begin
        sync_proc <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_COAST_LEAD) begin
        coast_lead_line_count <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_COAST_TRAIL) begin
        coast_trail_line_count <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_COAST_CTRL) begin
        coast_ctrl <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_OUT_FORMAT) begin
        out_format <= w_byte;
      end else if (aw_idx == `VSCOF_IDX_PHASE) begin
        phase_reg <= w_byte;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    if (i_s_axi_araddr[7:2] == `VSCOF_IDX_SYNC_CTRL) begin
      rd_word[7:0] = sync_ctrl;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_PULSE_WIDTH) begin
      rd_word[7:0] = sync_out_pulse_width;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_SYNC_PROC) begin
      rd_word[7:0] = sync_proc;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_COAST_LEAD) begin
      rd_word[7:0] = coast_lead_line_count;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_COAST_TRAIL) begin
      rd_word[7:0] = coast_trail_line_count;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_COAST_CTRL) begin
      rd_word[7:0] = coast_ctrl;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_OUT_FORMAT) begin
      rd_word[7:0] = out_format;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_PHASE) begin
      rd_word[7:0] = phase_reg;
    end else if (i_s_axi_araddr[7:2] == `VSCOF_IDX_STATUS) begin
      rd_word[1:0] = {coast, pol_high};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `VSCOF_RESP_OKAY;
    end else begin
      o_s_axi_arready <= ~ar_take & ~(o_s_axi_rvalid & ~i_s_axi_rready);
      if (ar_take) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_word;
        o_s_axi_rresp <= rd_ok ? `VSCOF_RESP_OKAY : `VSCOF_RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Input sync polarity: the shorter of the two phases is the pulse.
  logic hs_prev, hs_lead;
  logic [11:0] run_cnt, hi_len, lo_len;
  assign hs_lead = pr && (hs_s != hs_prev) && (hs_s == pol_high);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      hs_prev <= 1'b0;
      run_cnt <= 12'h000;
      hi_len <= 12'h000;
      lo_len <= 12'h000;
      pol_high <= 1'b1;
    end else begin
      pol_high <= hi_len <= lo_len;
      if (pr) begin
        hs_prev <= hs_s;
        if (hs_s != hs_prev) begin
          run_cnt <= 12'h001;
          if (hs_prev) begin
            hi_len <= run_cnt;
          end else begin
            lo_len <= run_cnt;
          end
        end else if (run_cnt != 12'hfff) begin
          run_cnt <= run_cnt + 12'h001;
        end
      end
    end
  end

  // Output pulse is rebuilt from the leading edge, width in pixels.
  logic [7:0] sync_cnt;
  logic pulse_now, chroma_odd;
  assign pulse_now = hs_lead ? (sync_out_pulse_width != 8'h00) : (sync_cnt != 8'h00);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync_cnt <= 8'h00;
      chroma_odd <= 1'b0;
    end else if (pr) begin
      if (hs_lead) begin
        sync_cnt <= (sync_out_pulse_width == 8'h00) ? 8'h00 : sync_out_pulse_width - 8'h01;
        chroma_odd <= 1'b1;
      end else begin
        sync_cnt <= (sync_cnt == 8'h00) ? 8'h00 : sync_cnt - 8'h01;
        chroma_odd <= ~chroma_odd;
      end
    end
  end

  // Data, sync and chroma phase share one pipeline so they stay aligned.
  logic [23:0] pipe_px [`VSCOF_PIPE_DEPTH];
  logic [`VSCOF_PIPE_DEPTH-1:0] pipe_hs, pipe_od;
  logic [23:0] px;
  logic ho, od;
  assign px = pipe_px[`VSCOF_PIPE_DEPTH-1];
  assign ho = pipe_hs[`VSCOF_PIPE_DEPTH-1];
  assign od = pipe_od[`VSCOF_PIPE_DEPTH-1];
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pipe_hs <= '0;
      pipe_od <= '0;
      for (int i = 0; i < `VSCOF_PIPE_DEPTH; i++) begin
        pipe_px[i] <= 24'h000000;
      end
    end else if (pr) begin
      pipe_hs <= {pipe_hs[`VSCOF_PIPE_DEPTH-2:0], pulse_now};
      pipe_od <= {pipe_od[`VSCOF_PIPE_DEPTH-2:0], ~chroma_odd};
      pipe_px[0] <= px_in;
      for (int i = 1; i < `VSCOF_PIPE_DEPTH; i++) begin
        pipe_px[i] <= pipe_px[i-1];
      end
    end
  end

  // Rising-half data goes out at the pixel fall, falling-half at the rise.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_red <= 8'h00;
      o_green <= 8'h00;
      o_blue <= 8'h00;
      o_line_sync_output <= 1'b0;
    end else if (pf) begin
      o_line_sync_output <= sync_ctrl[`VSCOF_BIT_SYNC_POL] ? ho : ~ho;
      case (fmt)
        vscof_pkg::fmt_422: begin
          o_red <= od ? px[23:16] : px[7:0];
          o_green <= px[15:8];
          o_blue <= od ? px[23:16] : px[7:0];
        end
        vscof_pkg::fmt_444ddr: begin
          o_red <= px[11:4];
          o_green <= {px[3:0], 4'h0};
          o_blue <= od ? px[23:16] : px[7:0];
        end
        default: begin
          o_red <= px[23:16];
          o_green <= px[15:8];
          o_blue <= px[7:0];
        end
      endcase
    end else if (pr && fmt == vscof_pkg::fmt_422) begin
      o_blue <= px[15:8];
    end else if (pr && fmt == vscof_pkg::fmt_444ddr) begin
      o_red <= px[23:16];
      o_green <= {px[15:12], 4'h0};
      o_blue <= px[15:8];
    end
  end

  // The quadrature clock is a tap of a delay line at half the high time.
  logic [`VSCOF_CLK_TAPS-1:0] clk_line;
  logic [4:0] half_len, hi_run;
  logic [3:0] tap;
  logic quad, test_clk, clk_pick;
  assign tap = (half_len[4:1] == 4'h0) ? 4'h1 : half_len[4:1];
  assign quad = clk_line[tap - 4'h1];
  always_comb begin
    case (clk_sel)
      vscof_pkg::clk_quad: clk_pick = quad;
      vscof_pkg::clk_double: clk_pick = pclk_d ^ quad;
      vscof_pkg::clk_test: clk_pick = test_clk;
      default: clk_pick = pclk_d;
    endcase
  end
  // The test clock can only reach half the system clock here.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pclk_d <= 1'b0;
      clk_line <= '0;
      half_len <= 5'h00;
      hi_run <= 5'h00;
      test_clk <= 1'b0;
      o_output_data_clock <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
      clk_line <= {clk_line[`VSCOF_CLK_TAPS-2:0], pclk_d};
      test_clk <= ~test_clk;
      o_output_data_clock <= clk_pick ^ out_format[`VSCOF_BIT_CLK_INV];
      if (pf) begin
        half_len <= hi_run;
        hi_run <= 5'h00;
      end else if (pclk_s && hi_run != 5'h1f) begin
        hi_run <= hi_run + 5'h01;
      end
    end
  end

  // Frame sync filter holds a leading edge that meets a line leading edge.
  logic vs_prev, vs_f, vs_f_seen, frame_tick, int_coast;
  logic [1:0] coast_src;
  assign coast_src = sync_proc[`VSCOF_MSB_COAST_SRC:`VSCOF_LSB_COAST_SRC];
  assign frame_tick = (coast_src == 2'h0) ? (pr && vs_s && !vs_prev) : (vs_f && !vs_f_seen);
  assign coast = coast_ctrl[`VSCOF_BIT_COAST_EXT] ? ext_coast_s : int_coast;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      vs_prev <= 1'b0;
      vs_f <= 1'b0;
      vs_f_seen <= 1'b0;
    end else begin
      vs_f_seen <= vs_f;
      if (pr) begin
        vs_prev <= vs_s;
        if (!(sync_proc[`VSCOF_BIT_VFILT_EN] && vs_s && !vs_prev && hs_lead)) begin
          vs_f <= vs_s;
        end
      end
    end
  end

  vscof_coast_gen u_coast (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_line_tick(hs_lead),
    .i_frame_tick(frame_tick),
    .i_lead(coast_lead_line_count),
    .i_trail(coast_trail_line_count),
    .o_coast(int_coast)
  );

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pll_reference <= 1'b0;
      o_pll_coast <= 1'b0;
      o_sample_phase <= 5'h00;
    end else begin
      o_pll_reference <= (hs_s == pol_high) & ~coast;
      o_pll_coast <= coast;
      o_sample_phase <= phase_reg[`VSCOF_MSB_PHASE:0];
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  property p_width_load;
    pr && hs_lead && sync_out_pulse_width != 8'h00 |=> sync_cnt == $past(sync_out_pulse_width) - 8'h01;
  endproperty
  a_width_load: assert property (p_width_load) else $error("pulse width not loaded");
  property p_sync_pol;
    pf |=> o_line_sync_output == ($past(ho) ~^ $past(sync_ctrl[`VSCOF_BIT_SYNC_POL]));
  endproperty
  a_sync_pol: assert property (p_sync_pol) else $error("sync output polarity wrong");
  property p_pipe;
    pr |=> pipe_px[0] == $past(px_in) && pipe_hs[5] == $past(pipe_hs[4]);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline did not advance");
  property p_full;
    pf && fmt == vscof_pkg::fmt_444 |=> o_red == $past(px[23:16]) && o_blue == $past(px[7:0]);
  endproperty
  a_full: assert property (p_full) else $error("full mode data wrong");
  property p_half;
    pf && fmt == vscof_pkg::fmt_422 |=>
      o_green == $past(px[15:8]) && o_red == ($past(od) ? $past(px[23:16]) : $past(px[7:0]));
  endproperty
  a_half: assert property (p_half) else $error("chroma or luma misplaced");
  property p_luma_fall;
    pr && (fmt == vscof_pkg::fmt_422 || fmt == vscof_pkg::fmt_444ddr) |=> o_blue == $past(px[15:8]);
  endproperty
  a_luma_fall: assert property (p_luma_fall) else $error("secondary luma wrong");
  property p_ddr_rise;
    pf && fmt == vscof_pkg::fmt_444ddr |=> o_red == $past(px[11:4]) && o_green[3:0] == 4'h0;
  endproperty
  a_ddr_rise: assert property (p_ddr_rise) else $error("double-rate low half wrong");
  property p_coast_hold;
    coast |=> o_pll_coast && !o_pll_reference;
  endproperty
  a_coast_hold: assert property (p_coast_hold) else $error("reference not gated by coast");
  property p_vfilt;
    pr && sync_proc[`VSCOF_BIT_VFILT_EN] && vs_s && !vs_prev && hs_lead |=> vs_f == $past(vs_f);
  endproperty
  a_vfilt: assert property (p_vfilt) else $error("frame sync edge not held");
endmodule
`default_nettype wire

/* File: verification/vscof_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vscof_sink_model (
  // Receiver clock and captured sync.
  input wire logic i_pixel_clock,
  input wire logic i_line_sync,
  input wire logic i_active_high,
  // Width of the last sync pulse in pixel clocks.
  output logic [7:0] o_width
);
  logic [7:0] count = 8'h00;
  // Sampling on the rising edge keeps clear of updates that follow the fall.
  always @(posedge i_pixel_clock) begin
    if (i_line_sync === i_active_high) begin
      count <= count + 8'h01;
    end else if (count != 8'h00) begin
      o_width <= count;
      count <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: verification/video_sync_coast_output_formatter_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vscof_defs.svh"
module video_sync_coast_output_formatter_tb_top;
  logic i_clock = 1'h0, i_srst = 1'h1, i_pixel_clock = 1'h0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  logic i_hsync = 1'h0, i_vsync = 1'h0, i_coast = 1'h0, pol = 1'h1, vs_on = 1'h0;
  logic [7:0] i_red = 8'hc3, i_green = 8'h5a, i_blue = 8'h96;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_line_sync_output, o_output_data_clock;
  logic o_pll_reference, o_pll_coast;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
  logic [31:0] o_s_axi_rdata;
  logic [7:0] o_red, o_green, o_blue, rd, width;
  logic [4:0] o_sample_phase;
  int fail_count = 0, check_count = 0, pix = 0;
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  // The pixel clock is kept out of phase with the system clock on purpose.
  initial begin
    #7;
    forever #200 i_pixel_clock = ~i_pixel_clock;
  end
  always @(negedge i_pixel_clock) begin
    pix <= (pix == 19) ? 0 : pix + 1;
    i_hsync <= (pix < 2);
    i_vsync <= vs_on && (pix < 2);
  end
  vscof_formatter u_vscof_formatter (.i_clock, .i_srst, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_pixel_clock, .i_hsync, .i_vsync, .i_coast, .i_red, .i_green, .i_blue,
    .o_line_sync_output, .o_output_data_clock, .o_red, .o_green, .o_blue,
    .o_pll_reference, .o_pll_coast, .o_sample_phase);
  vscof_sink_model u_vscof_sink_model (.i_pixel_clock, .i_line_sync(o_line_sync_output),
    .i_active_high(pol), .o_width(width));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    i_s_axi_awaddr <= {idx, 2'h0};
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_awvalid <= 1'h1;
    i_s_axi_wvalid <= 1'h1;
    i_s_axi_bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clock);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
      if (o_s_axi_bvalid === 1'h1) break;
    end
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'h0;
    if (n == 200) begin
      check("write answer", 32'h1, 32'h0);
      report_and_stop();
    end
    @(posedge i_clock);
  endtask
  task automatic rd_reg(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    i_s_axi_araddr <= {idx, 2'h0};
    i_s_axi_arvalid <= 1'h1;
    i_s_axi_rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clock);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
      if (o_s_axi_rvalid === 1'h1) break;
    end
    d = o_s_axi_rdata[7:0];
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'h0;
    if (n == 200) begin
      check("read answer", 32'h1, 32'h0);
      report_and_stop();
    end
    @(posedge i_clock);
  endtask
  task automatic seen(input string what, input int c, input logic [7:0] v);
    logic hit = 1'h0;
    repeat (32) begin
      @(posedge i_clock);
      if ((c == 0 ? o_red : c == 1 ? o_green : o_blue) === v) hit = 1'h1;
    end
    check(what, 32'h1, {31'h0, hit});
  endtask
  task automatic t_regs();
    logic [5:0] ix[6] = '{`VSCOF_IDX_SYNC_CTRL, `VSCOF_IDX_PULSE_WIDTH, `VSCOF_IDX_SYNC_PROC,
      `VSCOF_IDX_COAST_LEAD, `VSCOF_IDX_COAST_TRAIL, `VSCOF_IDX_COAST_CTRL};
    logic [7:0] ex[6] = '{`VSCOF_RST_SYNC_CTRL, `VSCOF_RST_PULSE_WIDTH, `VSCOF_RST_SYNC_PROC,
      `VSCOF_RST_COAST_LEAD, `VSCOF_RST_COAST_TRAIL, `VSCOF_RST_COAST_CTRL};
    for (int k = 0; k < 6; k++) begin
      rd_reg(ix[k], rd, rs);
      check("reset value", {24'h0, ex[k]}, {24'h0, rd});
    end
    wr(`VSCOF_IDX_COAST_LEAD, 8'h07, rs);
    rd_reg(`VSCOF_IDX_COAST_LEAD, rd, rs);
    check("lead count", 32'h7, {24'h0, rd});
    wr(`VSCOF_IDX_COAST_LEAD, 8'h02, rs);
    wr(`VSCOF_IDX_SYNC_PROC, 8'h04, rs);
    wr(6'h3f, 8'h55, rs);
    check("unmapped write", 32'h2, {30'h0, rs});
    rd_reg(6'h3f, rd, rs);
    check("unmapped read", 32'h2, {30'h0, rs});
    $display("registers done");
  endtask
  task automatic t_sync();
    wr(`VSCOF_IDX_PULSE_WIDTH, 8'h04, rs);
    repeat (640) @(posedge i_clock);
    check("sync width", 32'h4, {24'h0, width});
    rd_reg(`VSCOF_IDX_STATUS, rd, rs);
    check("input polarity", 32'h1, {31'h0, rd[0]});
    wr(`VSCOF_IDX_SYNC_CTRL, 8'h00, rs);
    pol <= 1'h0;
    repeat (640) @(posedge i_clock);
    check("low sync width", 32'h4, {24'h0, width});
    wr(`VSCOF_IDX_PHASE, 8'hff, rs);
    check("phase", 32'h1f, {27'h0, o_sample_phase});
    $display("sync done");
  endtask
  task automatic t_modes();
    seen("full red", 0, 8'hc3);
    seen("full green", 1, 8'h5a);
    seen("full blue", 2, 8'h96);
    wr(`VSCOF_IDX_OUT_FORMAT, {6'h00, vscof_pkg::fmt_422}, rs);
    repeat (100) @(posedge i_clock);
    seen("luma green", 1, 8'h5a);
    seen("cb red", 0, 8'h96);
    seen("cr red", 0, 8'hc3);
    seen("chroma blue", 2, 8'h96);
    seen("luma blue", 2, 8'h5a);
    wr(`VSCOF_IDX_OUT_FORMAT, {6'h00, vscof_pkg::fmt_444ddr}, rs);
    repeat (100) @(posedge i_clock);
    seen("upper red", 0, 8'hc3);
    seen("lower red", 0, 8'ha9);
    seen("upper green", 1, 8'h50);
    seen("lower green", 1, 8'h60);
    seen("ddr blue luma", 2, 8'h5a);
    check("unused green", 32'h0, {28'h0, o_green[3:0]});
    $display("modes done");
  endtask
  task automatic clk_run(input logic [7:0] f, output int tg, output int eq);
    logic prev;
    wr(`VSCOF_IDX_OUT_FORMAT, f, rs);
    repeat (16) @(posedge i_clock);
    prev = o_output_data_clock;
    tg = 0;
    eq = 0;
    repeat (64) begin
      @(posedge i_clock);
      tg += (o_output_data_clock !== prev);
      eq += (o_output_data_clock === i_pixel_clock);
      prev = o_output_data_clock;
    end
  endtask
  task automatic t_clocks();
    int tg, eq, eq2;
    clk_run({4'h0, vscof_pkg::clk_pixel, 2'h0}, tg, eq);
    check("pixel edges", 32'h1, {31'h0, tg inside {[15:17]}});
    clk_run({4'h1, vscof_pkg::clk_pixel, 2'h0}, tg, eq2);
    check("inverted clock", 32'h40, 32'(eq + eq2));
    clk_run({4'h0, vscof_pkg::clk_quad, 2'h0}, tg, eq);
    check("quad edges", 32'h1, {31'h0, tg inside {[15:17]}});
    clk_run({4'h0, vscof_pkg::clk_double, 2'h0}, tg, eq);
    check("double edges", 32'h1, {31'h0, tg inside {[31:33]}});
    clk_run({4'h0, vscof_pkg::clk_test, 2'h0}, tg, eq);
    check("test edges", 32'h1, {31'h0, tg inside {[63:64]}});
    $display("clocks done");
  endtask
  task automatic ref_high(output int n);
    n = 0;
    repeat (200) begin
      @(posedge i_clock);
      n += (o_pll_reference === 1'h1);
    end
  endtask
  task automatic t_coast();
    int n;
    ref_high(n);
    check("reference runs", 32'h1, {31'h0, n > 0});
    i_coast <= 1'h1;
    repeat (8) @(posedge i_clock);
    check("coast level", 32'h1, {31'h0, o_pll_coast});
    ref_high(n);
    check("gated reference", 32'h0, 32'(n));
    i_coast <= 1'h0;
    $display("coast done");
  endtask
  // Frame sync rises with a line leading edge, so the filter has to move it.
  task automatic t_int_coast();
    int n;
    wr(`VSCOF_IDX_SYNC_PROC, 8'h44, rs);
    wr(`VSCOF_IDX_COAST_CTRL, 8'h00, rs);
    check("coast idle", 32'h0, {31'h0, o_pll_coast});
    vs_on <= 1'h1;
    for (n = 0; n < 400 && o_pll_coast !== 1'h1; n++) @(posedge i_clock);
    vs_on <= 1'h0;
    check("internal coast", 32'h1, {31'h0, o_pll_coast});
    if (n == 400) report_and_stop();
    repeat (1800) @(posedge i_clock);
    check("coast released", 32'h0, {31'h0, o_pll_coast});
    $display("internal coast done");
  endtask
  initial begin
    repeat (16) @(posedge i_clock);
    i_srst <= 1'h0;
    repeat (3) @(posedge i_clock);
    check("red after reset", 32'h0, {24'h0, o_red});
    t_regs();
    t_sync();
    t_modes();
    t_clocks();
    t_coast();
    t_int_coast();
    report_and_stop();
  end
endmodule
`default_nettype wire
